// ### include/alu_pkg.sv
package alu_pkg;

  // Register bus byte offsets
  localparam logic [7:0] CMD_OFFSET      = 8'h00;
  localparam logic [7:0] OPERAND_OFFSET  = 8'h04;
  localparam logic [7:0] WORKING_OFFSET  = 8'h08;
  localparam logic [7:0] STATUS_OFFSET   = 8'h0C;
  localparam logic [7:0] RESULT_OFFSET   = 8'h10;

  // Field positions
  localparam int OP_LSB       = 0;
  localparam int DEST_BIT     = 4;
  localparam int CARRY_BIT    = 0;
  localparam int HALF_BIT     = 1;
  localparam int ZERO_BIT     = 2;
  localparam int BUSY_BIT     = 3;
  localparam int FILE_WR_BIT  = 4;

  // Reset values
  localparam logic [7:0] WORKING_RESET = 8'h00;
  localparam logic [2:0] FLAGS_RESET   = 3'h0;

  // Destination select values
  localparam logic DEST_WORKING = 1'b0;
  localparam logic DEST_FILE    = 1'b1;

  // Operation codes
  typedef enum logic [2:0] {
    OP_NONE                    = 3'h0,
    OP_SUBTRACT_W_FROM_FILE    = 3'h1,
    OP_SUBTRACT_W_FROM_LITERAL = 3'h2,
    OP_SWAP_FILE_NIBBLES       = 3'h3,
    OP_XOR_W_WITH_FILE         = 3'h4,
    OP_XOR_LITERAL_WITH_W      = 3'h5
  } op_t;

  // Flags carried together
  typedef struct packed {
    logic zero;
    logic halfCarry;
    logic carry;
  } flags_t;

  // Result of one operation
  typedef struct packed {
    logic [7:0] value;
    flags_t     flags;
    logic       writeCarry;
    logic       writeHalf;
    logic       writeZero;
    logic       toFile;
  } alu_result_t;

endpackage

// ### src/alu_core.sv
`timescale 1ns/1ps
module alu_core (
  // Operands
  input  wire alu_pkg::op_t     op,
  input  wire logic             dest,
  input  wire logic [7:0]       working,
  input  wire logic [7:0]       operand,
  // Result
  output alu_pkg::alu_result_t  res
);

  logic [8:0] diff;
  logic [4:0] lowDiff;
  logic [7:0] minuend;

  // Literal or file value stands as the minuend
  always_comb begin
    minuend = operand;
    diff    = {1'b0, minuend} - {1'b0, working};
    lowDiff = {1'b0, minuend[3:0]} - {1'b0, working[3:0]};
  end

  // Operation select
  always_comb begin
    res = '0;
    unique case (op)
      alu_pkg::OP_SUBTRACT_W_FROM_FILE: begin
        res.value          = diff[7:0];
        res.flags.carry    = ~diff[8];
        res.flags.halfCarry = ~lowDiff[4];
        res.writeCarry     = 1'b1;
        res.writeHalf      = 1'b1;
        res.writeZero      = 1'b1;
        res.toFile         = dest;
      end
      alu_pkg::OP_SUBTRACT_W_FROM_LITERAL: begin
        res.value          = diff[7:0];
        res.flags.carry    = ~diff[8];
        res.flags.halfCarry = ~lowDiff[4];
        res.writeCarry     = 1'b1;
        res.writeHalf      = 1'b1;
        res.writeZero      = 1'b1;
      end
      alu_pkg::OP_SWAP_FILE_NIBBLES: begin
        res.value  = {operand[3:0], operand[7:4]};
        res.toFile = dest;
      end
      alu_pkg::OP_XOR_W_WITH_FILE: begin
        res.value     = working ^ operand;
        res.writeZero = 1'b1;
        res.toFile    = dest;
      end
      alu_pkg::OP_XOR_LITERAL_WITH_W: begin
        res.value     = working ^ operand;
        res.writeZero = 1'b1;
      end
      default: res = '0;
    endcase
    res.flags.zero = (res.value == 8'h00);
  end

endmodule

// ### src/subtract_swap_xor_alu.sv
// Implementation choices: the address map and the APB register port.
`timescale 1ns/1ps
// Operation
// - Subtract-W-from-file computes file minus W, goes to W on dest 0 or file on 1, updates C, DC, Z.
// - Carry clears when W exceeds the file value, half-carry clears when W's low nibble exceeds it.
// - Swap-nibbles exchanges the two nibbles of the file value and touches no flag.
// - Swap-nibbles result goes to W on dest 0 and back to the file register on dest 1.
// - XOR-W-with-file forms W xor file, routed by dest, updating only zero.
// - XOR-literal forms W xor an 8-bit literal into W, updating only zero.
// - Subtract-W-from-literal computes literal minus W into W, updating carry, half-carry and zero.
module subtract_swap_xor_alu (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // File register write port toward data memory
  output logic             fileWrite,
  output logic [7:0]       fileData
);

  logic [7:0]           working_reg;
  logic [7:0]           operand_reg;
  logic [7:0]           result_reg;
  logic                 fileFlag_reg;
  alu_pkg::flags_t      flags_reg;
  alu_pkg::op_t         op_reg;
  logic                 dest_reg;
  logic                 go_reg;
  alu_pkg::alu_result_t res;
  logic                 setup;
  logic                 wrEn;
  logic                 mapped;
  // Writes qualified by the answered access phase
  logic                 accessWr;
  logic                 cmdHit;
  logic                 operandHit;
  logic                 workingHit;
  logic                 statusHit;
  // Execution qualifiers
  logic                 legalOp;
  logic                 execute;
  logic                 toWorking;
  logic                 toFile;
  // Read path ahead of the prdata flop
  logic [31:0]          readData;

  // Register map, one aligned word each, low bits only:
  //   command - operation code and destination select
  //   operand - file value or literal for the next command
  //   working - W, loaded by software or by a result
  //   status  - carry, half carry, zero, busy, last result went to file
  //   result  - last result, read only; writes to it are accepted and dropped
  // Setup and access phase decode
  assign setup  = psel & ~penable;
  assign wrEn   = psel & penable & pwrite;
  assign mapped = paddr inside {alu_pkg::CMD_OFFSET, alu_pkg::OPERAND_OFFSET,
                                alu_pkg::WORKING_OFFSET, alu_pkg::STATUS_OFFSET,
                                alu_pkg::RESULT_OFFSET};

  // A write lands only at the edge where the access phase is answered
  assign accessWr   = wrEn & pready;
  assign cmdHit     = accessWr & (paddr == alu_pkg::CMD_OFFSET);
  assign operandHit = accessWr & (paddr == alu_pkg::OPERAND_OFFSET);
  assign workingHit = accessWr & (paddr == alu_pkg::WORKING_OFFSET);
  assign statusHit  = accessWr & (paddr == alu_pkg::STATUS_OFFSET);

  // Codes 6 and 7 decode to no instruction; they must leave W and the result alone
  assign legalOp = op_reg inside {alu_pkg::OP_SUBTRACT_W_FROM_FILE,
                                  alu_pkg::OP_SUBTRACT_W_FROM_LITERAL,
                                  alu_pkg::OP_SWAP_FILE_NIBBLES,
                                  alu_pkg::OP_XOR_W_WITH_FILE,
                                  alu_pkg::OP_XOR_LITERAL_WITH_W};

  // Execution slot follows the command write by one cycle
  assign execute   = go_reg & legalOp;
  assign toFile    = execute & res.toFile;
  assign toWorking = execute & ~res.toFile;

  // Operands come from held registers, so bus timing never reaches the datapath
  alu_core core (
    .op      (op_reg),
    .dest    (dest_reg),
    .working (working_reg),
    .operand (operand_reg),
    .res     (res)
  );

  // Access phase answered one cycle after setup, no wait states
  // Setup is decoded with penable low, so back-to-back transfers need no gap
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~mapped;
    end
  end

  // Command fields held for readback and for the datapath
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      op_reg   <= alu_pkg::OP_NONE;
      dest_reg <= alu_pkg::DEST_WORKING;
    end else if (cmdHit) begin
      op_reg   <= alu_pkg::op_t'(pwdata[alu_pkg::OP_LSB +: 3]);
      dest_reg <= pwdata[alu_pkg::DEST_BIT];
    end
  end

  // Launch strobe, one cycle for each command write
  // Busy on the status word is this strobe; a read whose setup cycle directly follows the command write still sees it high
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      go_reg <= 1'b0;
    end else begin
      go_reg <= cmdHit;
    end
  end

  // File value or literal; the datapath treats both the same
  // Loaded ahead of the command; a later load does not rerun the operation
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      operand_reg <= 8'h00;
    end else if (operandHit) begin
      operand_reg <= pwdata[7:0];
    end
  end

  // Working register: result when destination is W, else software load
  // Execution wins a same-edge software load, so a result is never lost
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      working_reg <= alu_pkg::WORKING_RESET;
    end else if (toWorking) begin
      working_reg <= res.value;
    end else if (workingHit) begin
      working_reg <= pwdata[7:0];
    end
  end

  // Flags: only those the operation owns are updated; swap touches none
  // Any launch strobe wins a same-edge status write, even for swap or an idle code
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      flags_reg <= alu_pkg::FLAGS_RESET;
    end else if (go_reg) begin
      if (res.writeCarry) flags_reg.carry <= res.flags.carry;
      if (res.writeHalf) flags_reg.halfCarry <= res.flags.halfCarry;
      if (res.writeZero) flags_reg.zero <= res.flags.zero;
    end else if (statusHit) begin
      flags_reg <= alu_pkg::flags_t'(pwdata[2:0]);
    end
  end

  // File write strobe, one cycle pulse for each file destination
  // The data memory sees exactly one write per file-destination command
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      fileWrite <= 1'b0;
    end else begin
      fileWrite <= toFile;
    end
  end

  // Result capture; fileData stands until the next execution
  // W-destination results refresh fileData too, but with no strobe it is ignored
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      result_reg <= 8'h00;
      fileData   <= 8'h00;
    end else if (execute) begin
      result_reg <= res.value;
      fileData   <= res.value;
    end
  end

  // Destination of the last result, read back as a status bit
  // Held across idle commands so software can tell where the result went
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      fileFlag_reg <= 1'b0;
    end else if (execute) begin
      fileFlag_reg <= res.toFile;
    end
  end

  // Read mux; unmapped offsets read as zero, command bit 3 reads as zero
  always_comb begin
    unique case (paddr)
      alu_pkg::CMD_OFFSET:     readData = {27'h0, dest_reg, 1'b0, op_reg};
      alu_pkg::OPERAND_OFFSET: readData = {24'h0, operand_reg};
      alu_pkg::WORKING_OFFSET: readData = {24'h0, working_reg};
      alu_pkg::STATUS_OFFSET:  readData = {27'h0, fileFlag_reg, go_reg, flags_reg};
      alu_pkg::RESULT_OFFSET:  readData = {24'h0, result_reg};
      default:                 readData = 32'h0000_0000;
    endcase
  end

  // Read data registered in the setup cycle
  // Holding it outside setup keeps it stable for the whole access phase
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (setup) begin
      prdata <= readData;
    end
  end

endmodule

// ### testbench/alu_checker.sv
`timescale 1ns/1ps
module alu_checker (
  // Clock and reset
  input wire logic        clock,
  input wire logic        rst,
  // Bus
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // File port
  input wire logic        fileWrite,
  input wire logic [7:0]  fileData
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // Command decode seen on the bus
  wire cmdWr = psel && penable && pwrite && paddr == alu_pkg::CMD_OFFSET;
  wire litOp = pwdata[2:0] == 3'h2 || pwdata[2:0] == 3'h5;
  wire fileOp = pwdata[4] && (pwdata[2:0] == 3'h1 || pwdata[2:0] == 3'h3 || pwdata[2:0] == 3'h4);
  AST_ACCESS_READY: assert property (psel && penable |-> pready)
    else $error("no ready in access phase");
  AST_READY_ONLY: assert property (pready |-> psel && penable) else $error("stray ready");
  AST_READY_PULSE: assert property (pready |=> !pready) else $error("ready too long");
  AST_ERR_READY: assert property (pslverr |-> pready) else $error("error without ready");
  AST_ERR_ZERO: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read not zero");
  AST_UPPER_ZERO: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  AST_FILE_DEST: assert property (cmdWr && fileOp |-> ##[1:3] fileWrite)
    else $error("file write missing");
  AST_W_DEST: assert property (cmdWr && (!pwdata[4] || litOp) |-> ##1 !fileWrite [*3])
    else $error("unexpected file write");
  AST_FILE_PULSE: assert property (fileWrite |=> !fileWrite) else $error("file write too long");
  AST_FILE_DATA_HOLD: assert property (!$past(cmdWr, 2) |-> $stable(fileData))
    else $error("file data moved without a command");
  // Main scenarios
  cover property (cmdWr && fileOp);
  cover property (cmdWr && litOp);
  cover property (pslverr);
endmodule
bind subtract_swap_xor_alu alu_checker chk (.clock, .rst, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .fileWrite, .fileData);

// ### testbench/data_memory_model.sv
`timescale 1ns/1ps
module data_memory_model (
  // Clock and reset
  input wire logic       clock,
  input wire logic       rst,
  // Write port
  input wire logic       fileWrite,
  input wire logic [7:0] fileData,
  // Observation
  output int             writes,
  output logic [7:0]     stored
);
  // Capture each file write; count catches doubled pulses
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      writes <= 0;
      stored <= 8'h00;
    end else if (fileWrite) begin
      writes <= writes + 1;
      stored <= fileData;
    end
  end
endmodule

// ### testbench/tb_subtract_swap_xor_alu.sv
`timescale 1ns/1ps
module tb_subtract_swap_xor_alu;
  logic        clock = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00, fileData, stored;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, fileWrite, err;
  int          fails = 0, cmp_count = 0, writes;
  subtract_swap_xor_alu DUT (.clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .fileWrite, .fileData);
  data_memory_model mem (.clock, .rst, .fileWrite, .fileData, .writes, .stored);
  // 250 MHz clock
  initial begin
    forever #2 clock = ~clock;
  end
  task automatic check(input logic [31:0] got, exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // One APB transfer; waits on pready, never a fixed count
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge clock); n++; end while (pready !== 1'b1 && n < 16);
    check({31'h0, pready}, 32'h1, "ready");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  // Load operands, issue command, judge W, flags, result and file port
  task automatic exec(input logic [4:0] cmd, input logic [7:0] w, f, input logic [2:0] st,
                      input logic [7:0] ev, input logic [2:0] ef, input logic tf);
    int n0;
    n0 = writes;
    apb(1'b1, alu_pkg::WORKING_OFFSET, {24'h0, w});
    apb(1'b1, alu_pkg::OPERAND_OFFSET, {24'h0, f});
    apb(1'b1, alu_pkg::STATUS_OFFSET, {29'h0, st});
    apb(1'b1, alu_pkg::CMD_OFFSET, {27'h0, cmd});
    repeat (2) @(posedge clock);
    apb(1'b0, alu_pkg::WORKING_OFFSET, 32'h0);
    check(rd, {24'h0, tf ? w : ev}, "working");
    apb(1'b0, alu_pkg::STATUS_OFFSET, 32'h0);
    check({27'h0, rd[4:0]}, {27'h0, tf, 1'b0, ef}, "status");
    apb(1'b0, alu_pkg::RESULT_OFFSET, 32'h0);
    check(rd, {24'h0, ev}, "result");
    check(32'(writes - n0), {31'h0, tf}, "file writes");
    if (tf) check({24'h0, stored}, {24'h0, ev}, "file data");
  endtask
  task automatic t_regs;
    int n0;
    apb(1'b0, alu_pkg::WORKING_OFFSET, 32'h0);
    check(rd, {24'h0, alu_pkg::WORKING_RESET}, "working reset");
    check({31'h0, err}, 32'h0, "mapped read");
    apb(1'b0, 8'h20, 32'h0);
    check({31'h0, err}, 32'h1, "refused");
    check(rd, 32'h0, "refused data");
    apb(1'b1, 8'h20, 32'h0000_00FF);
    check({31'h0, err}, 32'h1, "refused write");
    // Idle command code with file destination must change nothing
    n0 = writes;
    apb(1'b1, alu_pkg::WORKING_OFFSET, 32'h0000_005C);
    apb(1'b1, alu_pkg::OPERAND_OFFSET, 32'h0000_00A7);
    apb(1'b1, alu_pkg::CMD_OFFSET, 32'h0000_0010);
    repeat (2) @(posedge clock);
    apb(1'b0, alu_pkg::CMD_OFFSET, 32'h0);
    check(rd, 32'h0000_0010, "command readback");
    apb(1'b0, alu_pkg::OPERAND_OFFSET, 32'h0);
    check(rd, 32'h0000_00A7, "operand readback");
    apb(1'b0, alu_pkg::WORKING_OFFSET, 32'h0);
    check(rd, 32'h0000_005C, "idle command working");
    check(32'(writes - n0), 32'h0, "idle command writes");
    $display("test regs done");
  endtask
  task automatic t_sub;
    exec(5'h11, 8'h36, 8'h35, 3'h7, 8'hFF, 3'h0, 1'b1);
    exec(5'h01, 8'h3A, 8'h3A, 3'h0, 8'h00, 3'h7, 1'b0);
    exec(5'h01, 8'h01, 8'h50, 3'h6, 8'h4F, 3'h1, 1'b0);
    exec(5'h12, 8'h01, 8'h10, 3'h6, 8'h0F, 3'h1, 1'b0);
    exec(5'h02, 8'h10, 8'h0F, 3'h5, 8'hFF, 3'h2, 1'b0);
    $display("test subtract done");
  endtask
  task automatic t_swap;
    exec(5'h13, 8'h11, 8'hA5, 3'h5, 8'h5A, 3'h5, 1'b1);
    exec(5'h03, 8'h11, 8'h3C, 3'h2, 8'hC3, 3'h2, 1'b0);
    $display("test swap done");
  endtask
  task automatic t_xor;
    exec(5'h04, 8'h5A, 8'h5A, 3'h3, 8'h00, 3'h7, 1'b0);
    exec(5'h14, 8'h0F, 8'hF0, 3'h7, 8'hFF, 3'h3, 1'b1);
    exec(5'h15, 8'hF0, 8'h0F, 3'h4, 8'hFF, 3'h0, 1'b0);
    exec(5'h05, 8'hAA, 8'hAA, 3'h3, 8'h00, 3'h7, 1'b0);
    $display("test xor done");
  endtask
  task automatic complete_run;
    $display("checks %0d fails %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    t_regs();
    t_sub();
    t_swap();
    t_xor();
    complete_run();
  end
  // Watchdog, far beyond the few hundred cycles needed
  initial begin
    #40000;
    fails++;
    $display("ERROR %0t watchdog", $time);
    complete_run();
  end
endmodule
